// file: sfep_regs.svh
// Opcodes, frame lengths, alignment masks and timing defaults of the flash sequencer.
// Assumes the core clock runs at SFEP_CLK_MHZ; times are in microseconds.
`ifndef SFEP_REGS_SVH
`define SFEP_REGS_SVH

`define SFEP_OP_SECTOR      8'h20
`define SFEP_OP_BLK32       8'h52
`define SFEP_OP_BLK64       8'hd8
`define SFEP_OP_CHIP_A      8'h60
`define SFEP_OP_CHIP_B      8'hc7
`define SFEP_OP_PAGE        8'h02
`define SFEP_OP_QPAGE       8'h38
`define SFEP_OP_QREAD_A     8'heb
`define SFEP_OP_QREAD_B     8'he7
`define SFEP_OP_MODE_RESET  8'hff

`define SFEP_OPC_END        6'd7
`define SFEP_SINGLE_HDR     6'd32
`define SFEP_QUAD_HDR       6'd14
`define SFEP_QREAD_IND_END  6'd15
`define SFEP_ENH_ADDR_END   6'd6
`define SFEP_ENH_IND_END    6'd7
`define SFEP_CHIP_BITS      6'd8
`define SFEP_CNT_MAX        6'd63

`define SFEP_SECTOR_MASK    24'hfff000
`define SFEP_BLK32_MASK     24'hff8000
`define SFEP_BLK64_MASK     24'hff0000
`define SFEP_PAGE_MASK      24'hffff00

`define SFEP_CLK_MHZ        100
`define SFEP_SECTOR_WIPE_US 1000
`define SFEP_BLOCK_WIPE_US  10000
`define SFEP_ARRAY_WIPE_US  100000
`define SFEP_PAGE_WRITE_US  1000

`endif

// file: sfep_pkg.sv
// Types shared by the flash sequencer modules.
// Assumes sfep_regs.svh is on the include path.
`include "sfep_regs.svh"

package sfep_pkg;

   typedef enum logic [2:0] {
      OP_NONE, OP_SECTOR, OP_BLK32, OP_BLK64, OP_CHIP, OP_PAGE, OP_QPAGE
   } sfep_op_t;

   typedef enum {ST_IDLE, ST_CHECK, ST_ERASE, ST_PROG, ST_WAIT, ST_DONE} sfep_state_t;

   // Frame summary left standing in the link domain after select_bar rises
   typedef struct packed {
      logic [7:0]  op;
      logic [23:0] addr;
      logic [5:0]  cnt;
      logic        on_byte;
      logic        got_byte;
      logic        enh;
   } sfep_frame_t;

   typedef struct packed {
      logic [3:0] block_protect_bits;
      logic       protect_scheme_select;
      logic       bp_area_hit;
      logic       lock_area_hit;
      logic       any_lock_set;
   } sfep_prot_t;

   typedef struct packed {
      logic        erase;
      sfep_op_t    kind;
      logic        prog;
      logic [23:0] addr;
      logic [7:0]  wdata;
   } sfep_arr_t;

   function automatic logic sfep_toggles(input logic [7:0] p);
      return &(p[7:4] ^ p[3:0]);
   endfunction

   function automatic logic [23:0] sfep_align(input sfep_op_t k, input logic [23:0] a);
      logic [23:0] m;
      m = 24'hffffff;
      case (k)
         OP_SECTOR:        m = `SFEP_SECTOR_MASK;
         OP_BLK32:         m = `SFEP_BLK32_MASK;
         OP_BLK64:         m = `SFEP_BLK64_MASK;
         OP_PAGE, OP_QPAGE: m = `SFEP_PAGE_MASK;
         OP_CHIP:          m = 24'h000000;
         default:          m = 24'hffffff;
      endcase
      return a & m;
   endfunction

endpackage

// file: sfep_timer.sv
// Self-timed cycle counter for erase and program.
// Assumes load is a one-cycle pulse on clk; done pulses once as the count runs out.
`timescale 1ns/1ps

module sfep_timer (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        load,
   input  wire logic [31:0] count,
   output      logic        done
);
   logic [31:0] cnt_ff;
   logic [31:0] nxt_cnt;

   always_comb begin
      nxt_cnt = cnt_ff;
      if (load) begin
         nxt_cnt = count;
      end else if (cnt_ff != 32'h0000_0000) begin
         nxt_cnt = cnt_ff - 32'h0000_0001;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_ff <= 32'h0000_0000;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   assign done = (cnt_ff == 32'h0000_0001);

endmodule

// file: sfep_link.sv
// Serial-clock side: opcode, address, indicator and data capture, page buffer.
// Assumes sclk stands still while select_bar is high; the frame summary is then stable.
`timescale 1ns/1ps
`include "sfep_regs.svh"

module sfep_link
   import sfep_pkg::*;
(
   input  wire logic        sclk,
   input  wire logic        select_bar,
   input  wire logic        link_rst,
   input  wire logic [3:0]  io_in,
   input  wire logic        busy_lvl,
   input  wire logic        quad_en_lvl,
   input  wire logic [7:0]  rd_idx,
   output      logic [7:0]  rd_data,
   output      logic        rd_valid,
   output      sfep_frame_t frame,
   output      logic        enhance
);
   logic         fresh_ff;
   logic [5:0]   cnt_ff,   nxt_cnt;
   logic [7:0]   op_ff,    nxt_op;
   logic [23:0]  addr_ff,  nxt_addr;
   logic [7:0]   ind_ff,   nxt_ind;
   logic [7:0]   dat_ff,   nxt_dat;
   logic [2:0]   ph_ff,    nxt_ph;
   logic [7:0]   idx_ff,   nxt_idx;
   logic         got_ff,   nxt_got;
   logic         efr_ff,   nxt_efr;
   logic         enh_ff,   nxt_enh;
   logic         ones_ff,  nxt_ones;
   logic [255:0] mask_ff,  nxt_mask;
   logic [1:0]   busy_sync_ff;
   logic [1:0]   qe_sync_ff;
   logic [7:0]   pbuf [256];
   logic         wr_en;
   logic [7:0]   wr_pos;
   logic [5:0]   c;
   logic         enh_now;
   logic         quad_ok;
   logic         byte_done;
   logic         data_ph;

   // Set asynchronously while deselected so the first clock of a frame sees it
   always_ff @(posedge sclk or posedge select_bar) begin
      if (select_bar) begin
         fresh_ff <= 1'b1;
      end else begin
         fresh_ff <= 1'b0;
      end
   end

   always_comb begin
      c         = fresh_ff ? 6'd0 : cnt_ff;
      enh_now   = fresh_ff ? enh_ff : efr_ff;
      quad_ok   = qe_sync_ff[1] & ~busy_sync_ff[1];
      nxt_cnt   = (c == `SFEP_CNT_MAX) ? c : c + 6'd1;
      nxt_op    = op_ff;
      nxt_addr  = addr_ff;
      nxt_ind   = ind_ff;
      nxt_dat   = dat_ff;
      nxt_ph    = ph_ff;
      nxt_idx   = idx_ff;
      nxt_got   = got_ff;
      nxt_efr   = enh_now;
      nxt_enh   = enh_ff;
      nxt_ones  = fresh_ff ? io_in[0] : (ones_ff & io_in[0]);
      nxt_mask  = mask_ff;
      wr_en     = 1'b0;
      wr_pos    = addr_ff[7:0] + idx_ff;
      byte_done = 1'b0;
      data_ph   = 1'b0;
      if (enh_now) begin
         if (c < `SFEP_ENH_ADDR_END) begin
            nxt_addr = {addr_ff[19:0], io_in};
         end else if (c <= `SFEP_ENH_IND_END) begin
            nxt_ind = {ind_ff[3:0], io_in};
         end
         if (c == `SFEP_ENH_IND_END) begin
            nxt_enh = sfep_toggles({ind_ff[3:0], io_in}) & quad_ok;
            if (nxt_ones) begin
               nxt_enh = 1'b0;
            end
         end
      end else if (c <= `SFEP_OPC_END) begin
         nxt_op = {op_ff[6:0], io_in[0]};
         if (c == `SFEP_OPC_END) begin
            nxt_ph  = 3'd0;
            nxt_idx = 8'h00;
            nxt_got = 1'b0;
            if (!busy_sync_ff[1]) begin
               nxt_mask = '0;
            end
            if ({op_ff[6:0], io_in[0]} == `SFEP_OP_MODE_RESET) begin
               nxt_enh = 1'b0;
            end
         end
      end else begin
         case (op_ff)
            `SFEP_OP_SECTOR, `SFEP_OP_BLK32, `SFEP_OP_BLK64, `SFEP_OP_PAGE: begin
               if (c < `SFEP_SINGLE_HDR) begin
                  nxt_addr = {addr_ff[22:0], io_in[0]};
               end else if (op_ff == `SFEP_OP_PAGE) begin
                  nxt_dat   = {dat_ff[6:0], io_in[0]};
                  byte_done = (ph_ff == 3'd7);
                  data_ph   = 1'b1;
               end
            end
            `SFEP_OP_QPAGE: begin
               if (c < `SFEP_QUAD_HDR) begin
                  nxt_addr = {addr_ff[19:0], io_in};
               end else begin
                  nxt_dat   = {dat_ff[3:0], io_in};
                  byte_done = (ph_ff == 3'd1);
                  data_ph   = 1'b1;
               end
            end
            `SFEP_OP_QREAD_A, `SFEP_OP_QREAD_B: begin
               if (c < `SFEP_QUAD_HDR) begin
                  nxt_addr = {addr_ff[19:0], io_in};
               end else if (c <= `SFEP_QREAD_IND_END) begin
                  nxt_ind = {ind_ff[3:0], io_in};
               end
               if (c == `SFEP_QREAD_IND_END) begin
                  nxt_enh = sfep_toggles({ind_ff[3:0], io_in}) & quad_ok;
               end
            end
            default: begin
            end
         endcase
         if (byte_done) begin
            nxt_ph  = 3'd0;
            nxt_idx = idx_ff + 8'h01;
            nxt_got = 1'b1;
         // Phase runs only on data clocks, so header length never skews byte edges
         end else if (data_ph) begin
            nxt_ph = ph_ff + 3'd1;
         end
         // Buffer frozen while a cycle runs so the core can still drain it
         if (byte_done && !busy_sync_ff[1]) begin
            wr_en            = 1'b1;
            nxt_mask[wr_pos] = 1'b1;
         end
      end
   end

   always_ff @(posedge sclk or posedge link_rst) begin
      if (link_rst) begin
         cnt_ff       <= 6'd0;
         op_ff        <= 8'h00;
         addr_ff      <= 24'h000000;
         ind_ff       <= 8'h00;
         dat_ff       <= 8'h00;
         ph_ff        <= 3'd0;
         idx_ff       <= 8'h00;
         got_ff       <= 1'b0;
         efr_ff       <= 1'b0;
         enh_ff       <= 1'b0;
         ones_ff      <= 1'b0;
         mask_ff      <= '0;
         busy_sync_ff <= 2'b00;
         qe_sync_ff   <= 2'b00;
      end else begin
         cnt_ff       <= nxt_cnt;
         op_ff        <= nxt_op;
         addr_ff      <= nxt_addr;
         ind_ff       <= nxt_ind;
         dat_ff       <= nxt_dat;
         ph_ff        <= nxt_ph;
         idx_ff       <= nxt_idx;
         got_ff       <= nxt_got;
         efr_ff       <= nxt_efr;
         enh_ff       <= nxt_enh;
         ones_ff      <= nxt_ones;
         mask_ff      <= nxt_mask;
         busy_sync_ff <= {busy_sync_ff[0], busy_lvl};
         qe_sync_ff   <= {qe_sync_ff[0], quad_en_lvl};
      end
   end

   always_ff @(posedge sclk) begin
      if (wr_en) begin
         pbuf[wr_pos] <= nxt_dat;
      end
   end

   assign rd_data  = pbuf[rd_idx];
   assign rd_valid = mask_ff[rd_idx];
   assign enhance  = enh_ff;
   assign frame    = '{op: op_ff, addr: addr_ff, cnt: cnt_ff, on_byte: (ph_ff == 3'd0),
                       got_byte: got_ff, enh: efr_ff};

endmodule

// file: sfep_top.sv
// Serial flash erase and program sequencer with continuous-read enhance mode tracking.
// Assumes the status block owns the write latch and quad enable; array and lock map are outside.
// Operation
// - Toggling indicator after quad read address enters enhance mode, dropping next opcode.
// - Enhance mode only from the two quad-lane read opcodes, never dual-lane.
// - In enhance mode the first clocks of the next frame are address.
// - Non-toggling indicator or the mode reset opcode leaves enhance mode.
// - Indicator toggles only when each upper bit differs from its lower partner.
// - Upper three lanes ignored during single-lane erase, program and reset.
// - Sector erase sets the whole addressed sector to ones.
// - Erase rejected unless select rises right after last address bit.
// - 64K block erase sets the containing block to ones.
// - 32K block erase sets the containing block to ones.
// - Cycle starts on select rise; busy during it; completion clears busy and latch.
// - Protected target left unchanged but write latch still cleared.
// - Chip erase opcode-only on byte boundary; skipped if protected, latch cleared.
// - Page program clears bits; only the last 256 bytes are kept.
// - Data past the page end wraps to the page start.
// - Bytes not sent keep their contents.
// - Page program rejected unless select rises on a data byte boundary.
// - Reads rejected while a cycle runs, leaving the cycle alone.
// - Enhance read: address, indicator on four lanes, then four dummy clocks.
`timescale 1ns/1ps
`include "sfep_regs.svh"

module sfep_top
   import sfep_pkg::*;
#(
   parameter int unsigned SECTOR_WIPE_CYC = `SFEP_SECTOR_WIPE_US * `SFEP_CLK_MHZ,
   parameter int unsigned BLOCK_WIPE_CYC  = `SFEP_BLOCK_WIPE_US * `SFEP_CLK_MHZ,
   parameter int unsigned ARRAY_WIPE_CYC  = `SFEP_ARRAY_WIPE_US * `SFEP_CLK_MHZ,
   parameter int unsigned PAGE_WRITE_CYC  = `SFEP_PAGE_WRITE_US * `SFEP_CLK_MHZ
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       sclk,
   input  wire logic       select_bar,
   input  wire logic [3:0] io_in,
   output      logic [3:0] io_out,
   output      logic [3:0] io_oe,
   input  wire logic       write_latch_bit,
   input  wire logic       quad_lane_enable_bit,
   input  wire sfep_prot_t prot,
   output      logic       op_in_progress_bit,
   output      logic       write_latch_clr,
   output      logic       enhance_mode,
   output      logic       cmd_rejected,
   output      logic [23:0] chk_addr,
   output      sfep_arr_t  arr_cmd
);
   sfep_state_t state_ff, nxt_state;
   sfep_op_t    kind_ff,  nxt_kind;
   logic [23:0] addr_ff,  nxt_addr;
   logic [8:0]  idx_ff,   nxt_idx;
   logic        busy_ff,  nxt_busy;
   logic        wclr_ff,  nxt_wclr;
   logic        rej_ff,   nxt_rej;
   logic [23:0] chk_ff,   nxt_chk;
   sfep_arr_t   arr_ff,   nxt_arr;
   logic [1:0]  cs_sync_ff;
   logic        cs_q_ff;
   logic [1:0]  enh_sync_ff;
   logic        link_rst_ff;
   logic [3:0]  io_out_ff;
   logic [3:0]  io_oe_ff;

   sfep_frame_t frame;
   logic        link_enh;
   logic [7:0]  rd_data;
   logic        rd_valid;
   logic        frame_end;
   sfep_op_t    fkind;
   logic        protected_hit;
   logic        tmr_load;
   logic [31:0] tmr_count;
   logic        tmr_done;

   sfep_link u_link (
      .sclk        (sclk),
      .select_bar  (select_bar),
      .link_rst    (link_rst_ff),
      .io_in       (io_in),
      .busy_lvl    (busy_ff),
      .quad_en_lvl (quad_lane_enable_bit),
      .rd_idx      (idx_ff[7:0]),
      .rd_data     (rd_data),
      .rd_valid    (rd_valid),
      .frame       (frame),
      .enhance     (link_enh)
   );

   sfep_timer u_timer (
      .clk   (clk),
      .rst   (rst),
      .load  (tmr_load),
      .count (tmr_count),
      .done  (tmr_done)
   );

   // Link state is stable once select_bar has been high for the synchroniser delay
   assign frame_end = cs_sync_ff[1] & ~cs_q_ff;

   always_comb begin
      fkind = OP_NONE;
      if (!frame.enh) begin
         case (frame.op)
            `SFEP_OP_SECTOR: begin
               if (frame.cnt == `SFEP_SINGLE_HDR) fkind = OP_SECTOR;
            end
            `SFEP_OP_BLK32: begin
               if (frame.cnt == `SFEP_SINGLE_HDR) fkind = OP_BLK32;
            end
            `SFEP_OP_BLK64: begin
               if (frame.cnt == `SFEP_SINGLE_HDR) fkind = OP_BLK64;
            end
            `SFEP_OP_CHIP_A, `SFEP_OP_CHIP_B: begin
               if (frame.cnt == `SFEP_CHIP_BITS) fkind = OP_CHIP;
            end
            `SFEP_OP_PAGE: begin
               if (frame.got_byte && frame.on_byte) fkind = OP_PAGE;
            end
            `SFEP_OP_QPAGE: begin
               if (frame.got_byte && frame.on_byte && quad_lane_enable_bit) begin
                  fkind = OP_QPAGE;
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_comb begin
      if (kind_ff == OP_CHIP) begin
         protected_hit = prot.protect_scheme_select ? prot.any_lock_set
                                                    : (|prot.block_protect_bits);
      end else begin
         protected_hit = prot.protect_scheme_select ? prot.lock_area_hit
                                                    : prot.bp_area_hit;
      end
   end

   always_comb begin
      nxt_state  = state_ff;
      nxt_kind   = kind_ff;
      nxt_addr   = addr_ff;
      nxt_idx    = idx_ff;
      nxt_wclr   = 1'b0;
      nxt_rej    = 1'b0;
      nxt_chk    = chk_ff;
      nxt_arr    = arr_ff;
      nxt_arr.erase = 1'b0;
      nxt_arr.prog  = 1'b0;
      tmr_load   = 1'b0;
      tmr_count  = 32'h0000_0000;
      unique case (state_ff)
         ST_IDLE: begin
            if (frame_end && !frame.enh && frame.cnt != 6'd0) begin
               if (fkind == OP_NONE || !write_latch_bit) begin
                  nxt_rej = (frame.cnt > `SFEP_OPC_END);
               end else begin
                  nxt_kind  = fkind;
                  nxt_addr  = sfep_align(fkind, frame.addr);
                  nxt_chk   = sfep_align(fkind, frame.addr);
                  nxt_state = ST_CHECK;
               end
            end
         end
         ST_CHECK: begin
            if (protected_hit) begin
               nxt_state = ST_DONE;
            end else if (kind_ff == OP_PAGE || kind_ff == OP_QPAGE) begin
               nxt_idx   = 9'd0;
               nxt_state = ST_PROG;
            end else begin
               nxt_state = ST_ERASE;
            end
         end
         ST_ERASE: begin
            nxt_arr.erase = 1'b1;
            nxt_arr.kind  = kind_ff;
            nxt_arr.addr  = addr_ff;
            tmr_load      = 1'b1;
            case (kind_ff)
               OP_SECTOR: tmr_count = SECTOR_WIPE_CYC;
               OP_CHIP:   tmr_count = ARRAY_WIPE_CYC;
               default:   tmr_count = BLOCK_WIPE_CYC;
            endcase
            nxt_state = ST_WAIT;
         end
         ST_PROG: begin
            if (idx_ff[8]) begin
               tmr_load  = 1'b1;
               tmr_count = PAGE_WRITE_CYC;
               nxt_state = ST_WAIT;
            end else begin
               // Array ANDs the byte in, so only zeros are written
               nxt_arr.prog  = rd_valid;
               nxt_arr.kind  = kind_ff;
               nxt_arr.addr  = {addr_ff[23:8], idx_ff[7:0]};
               nxt_arr.wdata = rd_data;
               nxt_idx       = idx_ff + 9'd1;
            end
         end
         ST_WAIT: begin
            if (tmr_done) begin
               nxt_state = ST_DONE;
            end
         end
         ST_DONE: begin
            nxt_wclr  = 1'b1;
            nxt_state = ST_IDLE;
         end
      endcase
      nxt_busy = (nxt_state != ST_IDLE);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff    <= ST_IDLE;
         kind_ff     <= OP_NONE;
         addr_ff     <= 24'h000000;
         idx_ff      <= 9'h000;
         busy_ff     <= 1'b0;
         wclr_ff     <= 1'b0;
         rej_ff      <= 1'b0;
         chk_ff      <= 24'h000000;
         arr_ff      <= '0;
         cs_sync_ff  <= 2'b11;
         cs_q_ff     <= 1'b1;
         enh_sync_ff <= 2'b00;
         link_rst_ff <= 1'b1;
         io_out_ff   <= 4'h0;
         io_oe_ff    <= 4'h0;
      end else begin
         state_ff    <= nxt_state;
         kind_ff     <= nxt_kind;
         addr_ff     <= nxt_addr;
         idx_ff      <= nxt_idx;
         busy_ff     <= nxt_busy;
         wclr_ff     <= nxt_wclr;
         rej_ff      <= nxt_rej;
         chk_ff      <= nxt_chk;
         arr_ff      <= nxt_arr;
         cs_sync_ff  <= {cs_sync_ff[0], select_bar};
         cs_q_ff     <= cs_sync_ff[1];
         enh_sync_ff <= {enh_sync_ff[0], link_enh};
         link_rst_ff <= 1'b0;
         io_out_ff   <= 4'h0;
         io_oe_ff    <= 4'h0;
      end
   end

   // Read data path lives in the read block; lanes stay released here
   assign io_out             = io_out_ff;
   assign io_oe              = io_oe_ff;
   assign op_in_progress_bit = busy_ff;
   assign write_latch_clr    = wclr_ff;
   assign enhance_mode       = enh_sync_ff[1];
   assign cmd_rejected       = rej_ff;
   assign chk_addr           = chk_ff;
   assign arr_cmd            = arr_ff;

endmodule

// file: sfep_monitor.sv
// Output checker for the erase and program sequencer.
// Assumes one core clock domain with synchronous active-high reset.
`timescale 1ns/1ps

module sfep_monitor
   import sfep_pkg::*;
(
   input logic        clk,
   input logic        rst,
   input logic        select_bar,
   input logic [3:0]  io_out,
   input logic [3:0]  io_oe,
   input logic        op_in_progress_bit,
   input logic        write_latch_clr,
   input logic        cmd_rejected,
   input logic [23:0] chk_addr,
   input sfep_arr_t   arr_cmd
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_run;
      op_in_progress_bit && !write_latch_clr;
   endsequence

   clr_pulse_a: assert property (write_latch_clr |=> !write_latch_clr)
      else $error("latch clear longer than one cycle");
   clr_end_a: assert property (write_latch_clr |-> !op_in_progress_bit && $past(op_in_progress_bit))
      else $error("latch clear outside cycle end");
   busy_sel_a: assert property ($rose(op_in_progress_bit) |-> select_bar)
      else $error("cycle started while selected");
   wipe_hold_a: assert property (arr_cmd.erase |-> s_run ##1 s_run[*8])
      else $error("erase cycle cut short");
   sector_align_a: assert property (arr_cmd.erase && arr_cmd.kind == OP_SECTOR |-> arr_cmd.addr[11:0] == 12'h000)
      else $error("sector address not aligned");
   blk32_align_a: assert property (arr_cmd.erase && arr_cmd.kind == OP_BLK32 |-> arr_cmd.addr[14:0] == 15'h0000)
      else $error("block32 address not aligned");
   blk64_align_a: assert property (arr_cmd.erase && arr_cmd.kind == OP_BLK64 |-> arr_cmd.addr[15:0] == 16'h0000)
      else $error("block64 address not aligned");
   chip_zero_a: assert property (arr_cmd.erase && arr_cmd.kind == OP_CHIP |-> arr_cmd.addr == 24'h000000)
      else $error("chip erase address not zero");
   prog_page_a: assert property (arr_cmd.prog |-> op_in_progress_bit && arr_cmd.addr[23:8] == chk_addr[23:8])
      else $error("program left its page");
   rej_idle_a: assert property (cmd_rejected |-> !op_in_progress_bit ##1 !op_in_progress_bit)
      else $error("rejected frame started a cycle");
   lanes_off_a: assert property (io_oe == 4'h0 && io_out == 4'h0)
      else $error("lanes driven by the write path");
endmodule

bind sfep_top sfep_monitor u_mon (.clk(clk), .rst(rst), .select_bar(select_bar),
   .op_in_progress_bit(op_in_progress_bit), .write_latch_clr(write_latch_clr),
   .cmd_rejected(cmd_rejected), .chk_addr(chk_addr), .arr_cmd(arr_cmd), .io_out(io_out),
   .io_oe(io_oe));

// file: sfep_host.sv
// Host end of the serial link: select, serial clock and lanes.
// Assumes tb_top calls xfer; the serial clock stands still between frames.
`timescale 1ns/1ps

module sfep_host (
   output logic       sclk,
   output logic       select_bar,
   output logic [3:0] io_in
);
   initial begin
      sclk = 1'b0;
      select_bar = 1'b1;
      io_in = 4'h0;
   end

   // 12 ns period, under the advised quad data rate
   task automatic tick();
      #6 sclk = 1'b1;
      #6 sclk = 1'b0;
   endtask

   // Single-lane bits first, then nibbles, both msb first
   task automatic xfer(input logic [63:0] s, input int ns, input logic [63:0] q, input int nq);
      select_bar = 1'b0;
      for (int i = ns - 1; i >= 0; i--) begin
         io_in = {~io_in[3:1], s[i]};
         tick();
      end
      for (int i = nq - 1; i >= 0; i--) begin
         io_in = q[4*i+:4];
         tick();
      end
      #6 select_bar = 1'b1;
      io_in = ~io_in;
      #60;
   endtask
endmodule

// file: tb_top.sv
// Self-checking bench for the erase and program sequencer.
// Assumes sfep_host drives the link; the protection map is modelled here.
`timescale 1ns/1ps

module tb_top
   import sfep_pkg::*;
;
   localparam int unsigned WIPE = 400;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        sclk, select_bar, busy, clr, enh, rej;
   logic        wl = 1'b1, qe = 1'b1, sel = 1'b0, lk = 1'b0;
   logic [3:0]  io_in, bp = 4'h0;
   logic [23:0] chk_addr, er_a;
   logic [31:0] p0, pl;
   sfep_prot_t  prot;
   sfep_arr_t   arr;
   sfep_op_t    er_k;
   int          n_er, n_pr, n_cl, n_rj, n_bz, err_total, tests_run;
   logic [7:0]  ops [5] = '{8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7};
   sfep_op_t    kinds [5] = '{OP_SECTOR, OP_BLK32, OP_BLK64, OP_CHIP, OP_CHIP};
   logic [23:0] adrs [5] = '{24'h01a000, 24'h018000, 24'h010000, 24'h000000, 24'h000000};
   logic [7:0]  e_op [6] = '{8'heb, 8'h00, 8'h00, 8'he7, 8'hff, 8'h3b};
   logic [7:0]  e_ind [6] = '{8'ha5, 8'h5a, 8'haa, 8'h0f, 8'h00, 8'ha5};
   logic [5:0]  e_exp = 6'h0b;

   assign prot = '{bp, sel, chk_addr[23:16] == 8'h7f, chk_addr[23:16] == 8'h7e, lk};
   always #5 clk = ~clk;

   sfep_top #(.SECTOR_WIPE_CYC(WIPE), .BLOCK_WIPE_CYC(WIPE), .ARRAY_WIPE_CYC(WIPE),
      .PAGE_WRITE_CYC(WIPE)) u_dut (.clk(clk), .rst(rst), .sclk(sclk), .select_bar(select_bar),
      .io_in(io_in), .io_out(), .io_oe(), .write_latch_bit(wl), .quad_lane_enable_bit(qe),
      .prot(prot), .op_in_progress_bit(busy), .write_latch_clr(clr), .enhance_mode(enh),
      .cmd_rejected(rej), .chk_addr(chk_addr), .arr_cmd(arr));
   sfep_host u_host (.sclk(sclk), .select_bar(select_bar), .io_in(io_in));

   always @(posedge clk) begin
      if (arr.erase === 1'b1) begin
         n_er++;
         er_k = arr.kind;
         er_a = arr.addr;
      end
      if (arr.prog === 1'b1) begin
         if (n_pr == 0) p0 = {arr.addr, arr.wdata};
         pl = {arr.addr, arr.wdata};
         n_pr++;
      end
      n_cl += clr;
      n_rj += rej;
      n_bz += busy;
   end

   task automatic check(input logic [79:0] got, input logic [79:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic summarize();
      $display("checks %0d errors %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic zero();
      {n_er, n_pr, n_cl, n_rj, n_bz} = 160'h0;
   endtask

   // Bounded wait so a stuck cycle cannot hang the run
   task automatic settle();
      repeat (10) @(posedge clk);
      for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(posedge clk);
      repeat (4) @(posedge clk);
   endtask

   task automatic run(input logic [63:0] s, input int ns, input logic [63:0] q, input int nq);
      @(posedge clk) #1;
      zero();
      u_host.xfer(s, ns, q, nq);
      settle();
   endtask

   initial begin
      repeat (10) @(posedge clk);
      #1 rst = 1'b0;
      repeat (5) @(posedge clk);
      for (int k = 0; k < 5; k++) begin
         run({ops[k], 24'h01abcd} >> (k > 2 ? 24 : 0), k > 2 ? 8 : 32, 0, 0);
         check({8'(n_er), 8'(n_cl), 1'(n_bz > WIPE), er_k, er_a}, {16'h0101, 1'b1, kinds[k], adrs[k]});
      end
      run({8'h20, 24'h01abcd, 1'b0}, 33, 0, 0);
      check({8'(n_er), 8'(n_rj)}, 16'h0001);
      @(posedge clk) #1 wl = 1'b0;
      run({8'h20, 24'h01abcd}, 32, 0, 0);
      check({8'(n_er), 8'(n_cl), 8'(n_rj)}, 24'h000001);
      @(posedge clk) #1 wl = 1'b1;
      run({8'hd8, 24'h7f1234}, 32, 0, 0);
      check({8'(n_er), 8'(n_cl), 8'(n_bz)}, 24'h000102);
      @(posedge clk) #1 sel = 1'b1;
      run({8'h52, 24'h7e0000}, 32, 0, 0);
      check({8'(n_er), 8'(n_cl), 8'(n_bz)}, 24'h000102);
      @(posedge clk) #1 lk = 1'b1;
      run(8'hc7, 8, 0, 0);
      check({8'(n_er), 8'(n_cl), 8'(n_bz)}, 24'h000102);
      @(posedge clk) #1 {sel, lk, bp} = 6'h01;
      run(8'h60, 8, 0, 0);
      check({8'(n_er), 8'(n_cl), 8'(n_bz)}, 24'h000102);
      @(posedge clk) #1 bp = 4'h0;
      run({8'h02, 24'h0001ff, 16'ha53c}, 48, 0, 0);
      check({8'(n_pr), p0, pl}, {8'h02, 32'h0001003c, 32'h0001ffa5});
      run({8'h02, 24'h000300, 12'h5a5}, 44, 0, 0);
      check({8'(n_pr), 8'(n_rj)}, 16'h0001);
      run(8'h38, 8, {24'h000210, 8'hc3}, 8);
      check({8'(n_pr), pl}, {8'h01, 32'h000210c3});
      @(posedge clk) #1 qe = 1'b0;
      run(8'h38, 8, {24'h000210, 8'hc3}, 8);
      check({8'(n_pr), 8'(n_rj)}, 16'h0001);
      @(posedge clk) #1 qe = 1'b1;
      for (int k = 0; k < 6; k++) begin
         run(e_op[k], (k == 1 || k == 2) ? 0 : 8, {24'h000040, e_ind[k], 16'h0}, k == 4 ? 0 : 12);
         check(enh, e_exp[k]);
      end
      @(posedge clk) #1;
      zero();
      u_host.xfer({8'h20, 24'h020000}, 32, 0, 0);
      u_host.xfer(8'heb, 8, {24'h0, 8'ha5, 16'h0}, 12);
      settle();
      check({8'(n_er), 8'(n_rj), 7'h00, enh}, 24'h010000);
      summarize();
   end

   initial begin
      #1000000;
      err_total++;
      summarize();
   end
endmodule
